// ---- rtl/fes_pkg.sv ----
// How it works
// - Erase only ever raises array bits to one; the array is told to fill FFh.
// - Erase is ignored, with no error flags, unless the write enable latch is set.
// - Commands execute only on chip select rising after whole bytes; otherwise nothing changes.
// - Erase inside a locked sector is skipped, latch stays set, flag bits 1 and 5 set.
// - During an erase ready flag is low and busy high; completion reverses both.
// - Every erase end, good or failed, clears the write enable latch.
// - An erase running past its time limit clears the latch and sets erase error.
// - Erase busy time is the subsector, sector or bulk time chosen by opcode.
// - Subsector and sector erase accept any address inside and fill the region.
// - Bulk erase fills everything, but any locked sector refuses it with bits 1 and 5.
// - Address bits are sampled on the rising serial clock edge.
// - Header clocks are 8 plus address width in single, halved dual, quartered quad.
// - Page program runs self-timed for the program time once chip select rises.
// - Suspend sets flag bit 2 for a program or bit 6 for an erase.
// - After the suspend latency the ready flag bit 7 rises; host polls it.
// - If the operation ends within the latency it completes and clears bit 2 or 6.
// - Suspend state is volatile; after reset the flag status reads 80h.
// - One nesting level: erase then program suspended; resumes continue program, then erase.
// - While suspended, reads of the suspended page or sector are marked indeterminate.
// - Program into the erase-suspended sector is ignored, sets bit 4, latch unchanged.
// - A resumed erase does not re-check lock bits changed while suspended.
// - Resume acts on chip select rising and continues the latest suspended operation.
// - Resume is ignored when nothing is suspended.
// - Clear-flag command resets the erase, program and protection error bits.
package fes_pkg;

  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_CLRFLAG = 8'h50;
  localparam logic [7:0] OP_SSE_A = 8'h20;
  localparam logic [7:0] OP_SSE_B = 8'h52;
  localparam logic [7:0] OP_SE = 8'hD8;
  localparam logic [7:0] OP_BE_A = 8'hC7;
  localparam logic [7:0] OP_BE_B = 8'h60;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_SUSP = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7A;

  // Flag status bit positions.
  localparam int unsigned FSR_READY = 7;
  localparam int unsigned FSR_ESUSP = 6;
  localparam int unsigned FSR_EERR = 5;
  localparam int unsigned FSR_PERR = 4;
  localparam int unsigned FSR_PSUSP = 2;
  localparam int unsigned FSR_PROT = 1;
  localparam logic [7:0] FSR_RESET = 8'h80;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_DUAL = 2'h1;
  localparam logic [1:0] MODE_QUAD = 2'h2;

  localparam int unsigned ADDR_W_DEF = 24;
  localparam int unsigned MAX_ADDR_W = 32;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned PAGE_BITS = 8;
  localparam int unsigned SUBSECT_BITS = 12;
  localparam int unsigned SECT_BITS = 16;

  // Timing in microseconds, turned into 100 ns clock cycles, rounded up.
  localparam longint unsigned CLK_PERIOD_NS = 100;
  localparam longint unsigned SUBSECTOR_ERASE_TIME_US = 50000;
  localparam longint unsigned SECTOR_ERASE_TIME_US = 150000;
  localparam longint unsigned BULK_ERASE_TIME_US = 1000000;
  localparam longint unsigned PAGE_PROGRAM_TIME_US = 500;
  localparam longint unsigned SUSPEND_LATENCY_US = 30;
  localparam int unsigned SUBSECTOR_ERASE_CYC = 32'((SUBSECTOR_ERASE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned SECTOR_ERASE_CYC = 32'((SECTOR_ERASE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned BULK_ERASE_CYC = 32'((BULK_ERASE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned PAGE_PROGRAM_CYC = 32'((PAGE_PROGRAM_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] SUSP_LAT_CYC = 16'((SUSPEND_LATENCY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned TIMEOUT_MULT = 4;

  typedef enum logic [1:0] {FES_K_SUBSECT, FES_K_SECT, FES_K_BULK, FES_K_PROG} fes_kind_e;
  typedef enum logic [1:0] {FES_IDLE, FES_BUSY, FES_SUSP_WAIT} fes_state_e;

  // One array operation order, pulsed at completion.
  typedef struct packed {
    logic valid;
    fes_kind_e kind;
    logic [MAX_ADDR_W-1:0] base;
    logic [7:0] fill;
  } fes_arr_op_s;

  // Context of a running or suspended operation.
  typedef struct packed {
    fes_kind_e kind;
    logic [MAX_ADDR_W-1:0] addr;
    logic [31:0] rem;
    logic [31:0] el;
    logic [31:0] lim;
  } fes_ctx_s;

endpackage : fes_pkg

// ---- rtl/fes_seq.sv ----
`timescale 1ns/10ps
module fes_seq import fes_pkg::*; #(
  parameter int unsigned ADDR_W = ADDR_W_DEF,
  parameter int unsigned SUBSECTOR_ERASE_CYCLES = SUBSECTOR_ERASE_CYC,
  parameter int unsigned SECTOR_ERASE_CYCLES = SECTOR_ERASE_CYC,
  parameter int unsigned BULK_ERASE_CYCLES = BULK_ERASE_CYC,
  parameter int unsigned PAGE_PROGRAM_CYCLES = PAGE_PROGRAM_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_sck,
  input wire logic cs_n,
  input wire logic [3:0] serial_data_lines,
  input wire logic [1:0] io_mode,
  input wire logic [(1 << (ADDR_W - SECT_BITS))-1:0] sector_lock,
  input wire logic arr_ready,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic wel,
  output logic wip,
  output logic [7:0] flag_status,
  output fes_arr_op_s arr_op,
  output logic rd_indeterminate
);

  localparam int unsigned SH_W = 8 + ADDR_W;

  // Refuse address widths the sector and lock decoding cannot serve.
  if (ADDR_W % 4 != 0 || ADDR_W < 20 || ADDR_W > 28) begin : g_bad_addr_w
    $error("ADDR_W must be a multiple of 4 between 20 and 28.");
  end
  if (SUBSECTOR_ERASE_CYCLES == 0 || SECTOR_ERASE_CYCLES == 0 || BULK_ERASE_CYCLES == 0
      || PAGE_PROGRAM_CYCLES == 0) begin : g_bad_time
    $error("Operation cycle counts must be at least one.");
  end

  // Edges of one byte, or of opcode plus address, in the given lane mode.
  function automatic logic [CNT_W-1:0] edges_for(input logic [1:0] m, input logic with_addr);
    logic [CNT_W-1:0] per_byte;
    per_byte = CNT_W'(8);
    if (m == MODE_DUAL) begin
      per_byte = CNT_W'(4);
    end else if (m == MODE_QUAD) begin
      per_byte = CNT_W'(2);
    end
    return with_addr ? per_byte + CNT_W'(ADDR_W) * per_byte / CNT_W'(8) : per_byte;
  endfunction : edges_for

  // Shift one clock's worth of lanes into the header register.
  function automatic logic [SH_W-1:0] shift_in(input logic [SH_W-1:0] s, input logic [3:0] d,
                                               input logic [1:0] m);
    logic [SH_W-1:0] r;
    r = {s[SH_W-2:0], d[0]};
    if (m == MODE_DUAL) begin
      r = {s[SH_W-3:0], d[1:0]};
    end else if (m == MODE_QUAD) begin
      r = {s[SH_W-5:0], d};
    end
    return r;
  endfunction : shift_in

  // Self-timed length of each kind of operation.
  function automatic logic [31:0] op_time(input fes_kind_e k);
    logic [31:0] t;
    case (k)
      FES_K_SUBSECT: t = SUBSECTOR_ERASE_CYCLES;
      FES_K_SECT: t = SECTOR_ERASE_CYCLES;
      FES_K_BULK: t = BULK_ERASE_CYCLES;
      default: t = PAGE_PROGRAM_CYCLES;
    endcase
    return t;
  endfunction : op_time

  // Fresh context: region base, full time, and a timeout a few times longer.
  function automatic fes_ctx_s mk_ctx(input fes_kind_e k, input logic [ADDR_W-1:0] a);
    fes_ctx_s c;
    logic [ADDR_W-1:0] base;
    base = a;
    if (k == FES_K_SUBSECT) begin
      base = (a >> SUBSECT_BITS) << SUBSECT_BITS;
    end else if (k == FES_K_SECT) begin
      base = (a >> SECT_BITS) << SECT_BITS;
    end else if (k == FES_K_BULK) begin
      base = '0;
    end
    c.kind = k;
    c.addr = MAX_ADDR_W'(base);
    c.rem = op_time(k);
    c.el = '0;
    c.lim = 32'(op_time(k) * TIMEOUT_MULT);
    return c;
  endfunction : mk_ctx

  // Link domain. The frame restarts on the first edge after chip select fell.
  logic arm;
  logic ftog;
  logic [1:0] mode_l1;
  logic [1:0] mode_l2;
  logic [1:0] fmode;
  logic [SH_W-1:0] sh;
  logic [CNT_W-1:0] cnt;

  // Chip select high presets the arm flag, so no link edge is needed to end a frame.
  always_ff @(posedge link_sck or posedge cs_n) begin
    if (cs_n) begin
      arm <= 1'b1;
    end else begin
      arm <= 1'b0;
    end
  end

  // Mode is static configuration; it is resynchronised on the link clock.
  always_ff @(posedge link_sck or negedge rst_n) begin
    if (!rst_n) begin
      mode_l1 <= MODE_SINGLE;
      mode_l2 <= MODE_SINGLE;
    end else begin
      mode_l1 <= io_mode;
      mode_l2 <= mode_l1;
    end
  end

  // Opcode and address shift in on rising edges; data bits beyond the header are only counted.
  always_ff @(posedge link_sck or negedge rst_n) begin
    if (!rst_n) begin
      sh <= '0;
      cnt <= '0;
      fmode <= MODE_SINGLE;
      ftog <= 1'b0;
    end else if (arm) begin
      sh <= shift_in('0, serial_data_lines, mode_l2);
      cnt <= CNT_W'(1);
      fmode <= mode_l2;
      ftog <= ~ftog;
    end else begin
      if (cnt < edges_for(fmode, 1'b1)) begin
        sh <= shift_in(sh, serial_data_lines, fmode);
      end
      cnt <= cnt + CNT_W'(1);
    end
  end

  // System domain: chip select and the frame toggle cross by two flip-flops each.
  // The header words are read only after chip select is seen high, when the link is quiet.
  logic cs_s1;
  logic cs_s2;
  logic cs_s3;
  logic ft_s1;
  logic ft_s2;
  logic ft_seen;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      ft_s1 <= 1'b0;
      ft_s2 <= 1'b0;
      ft_seen <= 1'b0;
    end else begin
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      ft_s1 <= ftog;
      ft_s2 <= ft_s1;
      if (cs_s2 && !cs_s3) begin
        ft_seen <= ft_s2;
      end
    end
  end

  // Command decode at the end of a frame.
  wire new_frame = cs_s2 && !cs_s3 && (ft_s2 != ft_seen);
  wire [CNT_W-1:0] byte_edges = edges_for(fmode, 1'b0);
  wire [CNT_W-1:0] hdr_edges = edges_for(fmode, 1'b1);
  wire [CNT_W-1:0] data_edges = cnt - hdr_edges;
  wire is_short = new_frame && cnt == byte_edges;
  wire is_hdr = new_frame && cnt == hdr_edges;
  wire is_data = new_frame && cnt > hdr_edges && (data_edges & (byte_edges - CNT_W'(1))) == '0;
  wire [7:0] op_s = sh[7:0];
  wire [7:0] op_a = sh[SH_W-1 -: 8];
  wire [ADDR_W-1:0] cmd_addr = sh[ADDR_W-1:0];

  wire c_wren = is_short && op_s == OP_WREN;
  wire c_wrdi = is_short && op_s == OP_WRDI;
  wire c_clr = is_short && op_s == OP_CLRFLAG;
  wire c_susp = is_short && op_s == OP_SUSP;
  wire c_res = is_short && op_s == OP_RESUME;
  wire c_sse = is_hdr && (op_a == OP_SSE_A || op_a == OP_SSE_B);
  wire c_se = is_hdr && op_a == OP_SE;
  wire c_be = is_short && (op_s == OP_BE_A || op_s == OP_BE_B);
  wire c_pp = is_data && op_a == OP_PP;

  // Operation state.
  fes_state_e state;
  fes_ctx_s cur;
  fes_ctx_s e_ctx;
  fes_ctx_s p_ctx;
  logic e_susp;
  logic p_susp;
  logic [15:0] lat;

  wire idle = state == FES_IDLE;
  wire [ADDR_W-SECT_BITS-1:0] cmd_sect = cmd_addr[ADDR_W-1:SECT_BITS];
  wire lock_hit = sector_lock[cmd_sect];
  wire e_hit = e_susp && cmd_sect == e_ctx.addr[ADDR_W-1:SECT_BITS];
  wire er_cmd = c_sse || c_se || c_be;
  wire er_ok = idle && wel && !e_susp && !p_susp;
  wire er_prot = c_be ? |sector_lock : lock_hit;
  wire pp_ok = idle && wel && !p_susp;
  wire op_done = cur.rem == '0 && arr_ready;
  wire op_tmo = cur.el >= cur.lim;
  wire cur_prog = cur.kind == FES_K_PROG;
  wire [2:0] susp_bit = cur_prog ? 3'(FSR_PSUSP) : 3'(FSR_ESUSP);
  wire [2:0] err_bit = cur_prog ? 3'(FSR_PERR) : 3'(FSR_EERR);
  wire [ADDR_W-1:0] cur_base = cur.addr[ADDR_W-1:0];
  fes_kind_e er_kind;
  assign er_kind = c_be ? FES_K_BULK : (c_se ? FES_K_SECT : FES_K_SUBSECT);

  // Main sequencer. Error clears come first so that any set later in the same cycle wins.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= FES_IDLE;
      cur <= '0;
      e_ctx <= '0;
      p_ctx <= '0;
      e_susp <= 1'b0;
      p_susp <= 1'b0;
      lat <= '0;
      wel <= 1'b0;
      wip <= 1'b0;
      flag_status <= FSR_RESET;
      arr_op <= '0;
    end else begin
      arr_op.valid <= 1'b0;
      if (c_clr) begin
        flag_status[FSR_EERR] <= 1'b0;
        flag_status[FSR_PERR] <= 1'b0;
        flag_status[FSR_PROT] <= 1'b0;
      end
      case (state)
        FES_IDLE: begin
          if (c_wren) begin
            wel <= 1'b1;
          end else if (c_wrdi) begin
            wel <= 1'b0;
          end else if (er_cmd && er_ok) begin
            if (er_prot) begin
              flag_status[FSR_PROT] <= 1'b1;
              flag_status[FSR_EERR] <= 1'b1;
            end else begin
              cur <= mk_ctx(er_kind, cmd_addr);
              state <= FES_BUSY;
              wip <= 1'b1;
              flag_status[FSR_READY] <= 1'b0;
            end
          end else if (c_pp && pp_ok) begin
            if (e_hit) begin
              flag_status[FSR_PERR] <= 1'b1;
            end else if (lock_hit) begin
              flag_status[FSR_PROT] <= 1'b1;
              flag_status[FSR_PERR] <= 1'b1;
            end else begin
              cur <= mk_ctx(FES_K_PROG, cmd_addr);
              state <= FES_BUSY;
              wip <= 1'b1;
              flag_status[FSR_READY] <= 1'b0;
            end
          end else if (c_res && (p_susp || e_susp)) begin
            // The program is the later one, so it goes first; locks are not looked at again.
            if (p_susp) begin
              cur <= p_ctx;
              p_susp <= 1'b0;
              flag_status[FSR_PSUSP] <= 1'b0;
            end else begin
              cur <= e_ctx;
              e_susp <= 1'b0;
              flag_status[FSR_ESUSP] <= 1'b0;
            end
            state <= FES_BUSY;
            wip <= 1'b1;
            flag_status[FSR_READY] <= 1'b0;
          end
        end
        FES_BUSY, FES_SUSP_WAIT: begin
          cur.rem <= (cur.rem != '0) ? cur.rem - 32'd1 : '0;
          cur.el <= cur.el + 32'd1;
          if (op_tmo) begin
            state <= FES_IDLE;
            wip <= 1'b0;
            wel <= 1'b0;
            flag_status[err_bit] <= 1'b1;
            flag_status[susp_bit] <= 1'b0;
            flag_status[FSR_READY] <= 1'b1;
          end else if (op_done) begin
            // Completion inside the suspend latency finishes the work instead.
            state <= FES_IDLE;
            wip <= 1'b0;
            wel <= 1'b0;
            flag_status[susp_bit] <= 1'b0;
            flag_status[FSR_READY] <= 1'b1;
            arr_op.valid <= 1'b1;
            arr_op.kind <= cur.kind;
            arr_op.base <= MAX_ADDR_W'(cur_base);
            arr_op.fill <= ERASED_BYTE;
          end else if (state == FES_SUSP_WAIT) begin
            if (lat == '0) begin
              if (cur_prog) begin
                p_ctx <= cur;
                p_susp <= 1'b1;
              end else begin
                e_ctx <= cur;
                e_susp <= 1'b1;
              end
              state <= FES_IDLE;
              wip <= 1'b0;
              flag_status[FSR_READY] <= 1'b1;
            end else begin
              lat <= lat - 16'd1;
            end
          end else if (c_susp) begin
            state <= FES_SUSP_WAIT;
            lat <= SUSP_LAT_CYC;
            flag_status[susp_bit] <= 1'b1;
          end
        end
        default: begin
          state <= FES_IDLE;
        end
      endcase
    end
  end

  // Reads that fall in a suspended page or sector may see half-done data.
  wire rd_page_hit = p_susp && rd_addr[ADDR_W-1:PAGE_BITS] == p_ctx.addr[ADDR_W-1:PAGE_BITS];
  wire rd_sect_hit = e_susp && rd_addr[ADDR_W-1:SECT_BITS] == e_ctx.addr[ADDR_W-1:SECT_BITS];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_indeterminate <= 1'b0;
    end else begin
      rd_indeterminate <= rd_page_hit || rd_sect_hit;
    end
  end

endmodule : fes_seq

// ---- tb/fes_seq_monitor.sv ----
`timescale 1ns/10ps
module fes_seq_monitor import fes_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic wel,
  input wire logic wip,
  input wire logic [7:0] flag_status,
  input wire fes_arr_op_s arr_op
);
  logic [15:0] lat_cnt;

  // Cycles since a suspend bit rose; it saturates so a long wait never wraps back to a small count.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      lat_cnt <= 16'h0;
    else if ($rose(flag_status[FSR_PSUSP]) || $rose(flag_status[FSR_ESUSP]))
      lat_cnt <= 16'h1;
    else if (lat_cnt != 16'h0 && lat_cnt != 16'hFFFF)
      lat_cnt <= lat_cnt + 16'h1;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // The end state of an operation, and the region alignment of its order.
  sequence done_s;
    !wip && !wel && flag_status[FSR_READY];
  endsequence
  sequence aligned_s;
    (arr_op.kind != FES_K_SUBSECT || arr_op.base[11:0] == 12'h0) &&
    (arr_op.kind != FES_K_SECT || arr_op.base[15:0] == 16'h0) && (arr_op.kind != FES_K_BULK || arr_op.base == 32'h0);
  endsequence

  reset_value_a: assert property ($rose(rst_n) |-> flag_status == FSR_RESET && !wel && !wip)
    else $error("flag status not at its reset value");
  busy_flag_a: assert property (wip |-> !flag_status[FSR_READY])
    else $error("ready flag high while busy");
  done_state_a: assert property (arr_op.valid |-> done_s)
    else $error("completion without idle state");
  erase_fill_a: assert property (arr_op.valid && arr_op.kind != FES_K_PROG |-> arr_op.fill == ERASED_BYTE)
    else $error("erase fill not all ones");
  region_base_a: assert property (arr_op.valid |-> aligned_s)
    else $error("erase base not region aligned");
  wel_cs_a: assert property ($rose(wel) |-> cs_n && $past(cs_n))
    else $error("latch set inside a frame");
  start_cs_a: assert property ($rose(wip) |-> cs_n && $past(cs_n))
    else $error("operation started inside a frame");
  prot_flag_a: assert property ($rose(flag_status[FSR_PROT]) |-> wel && (flag_status[FSR_EERR] || flag_status[FSR_PERR]))
    else $error("protection flag without error bit or latch");
  ready_fall_a: assert property ($fell(flag_status[FSR_READY]) |-> wip)
    else $error("ready dropped without busy");
  susp_wait_a: assert property ($rose(flag_status[FSR_READY]) && (flag_status[FSR_PSUSP] || flag_status[FSR_ESUSP])
    |-> lat_cnt >= SUSP_LAT_CYC - 16'h2)
    else $error("suspended state reached early");
  susp_bound_a: assert property ($rose(flag_status[FSR_ESUSP]) && wip |-> ##[1:305] flag_status[FSR_READY])
    else $error("suspend never settled");
endmodule : fes_seq_monitor

bind fes_seq fes_seq_monitor u_fes_seq_monitor (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .wel(wel), .wip(wip),
  .flag_status(flag_status), .arr_op(arr_op));

// ---- tb/fes_host.sv ----
`timescale 1ns/10ps
module fes_host import fes_pkg::*; (
  output logic link_sck,
  output logic cs_n,
  output logic [3:0] serial_data_lines,
  input wire logic [1:0] io_mode
);
  // The serial clock stands low between frames, except for two settling edges after a mode change, and the released lines never hold a stale value.
  // Lane mode that the device's link side has last seen settle through its two resync stages.
  logic [1:0] last_mode;

  initial begin
    last_mode = MODE_SINGLE;
    link_sck = 1'b0;
    cs_n = 1'b1;
    serial_data_lines = 4'h5;
  end

  // One frame: opcode, then an address bits, then extra bits, MSB first over the active lanes.
  task automatic frame(input logic [7:0] op, input logic [31:0] ad, input int an, input int extra);
    logic [63:0] sr;
    int w;
    sr = {op, ad << (32 - an), 24'h0};
    w = (io_mode == MODE_QUAD) ? 4 : (io_mode == MODE_DUAL) ? 2 : 1;
    // The mode only crosses on link edges, so after a change two idle edges let it settle.
    // An even count keeps the frame toggle parity, so the next frame is not missed.
    if (io_mode != last_mode) begin
      repeat (2) begin
        #40 link_sck = 1'b1;
        #40 link_sck = 1'b0;
      end
      last_mode = io_mode;
      #40;
    end
    cs_n = 1'b0;
    #40;
    for (int i = 0; i < (8 + an + extra) / w; i++) begin
      // Data changes while the clock is low so each rising edge captures a settled bit.
      serial_data_lines = (w == 4) ? sr[63:60] : (w == 2) ? {2'h0, sr[63:62]} : {3'h0, sr[63]};
      sr = sr << w;
      #40 link_sck = 1'b1;
      #40 link_sck = 1'b0;
    end
    #40 cs_n = 1'b1;
    serial_data_lines = ~serial_data_lines;
    #600;
  endtask : frame
endmodule : fes_host

// ---- tb/flash_erase_suspend_sequencer_bench.sv ----
`timescale 1ns/10ps
module flash_erase_suspend_sequencer_bench import fes_pkg::*;;
  localparam int AW = 20;
  localparam int SSE = 400;
  localparam int SE = 500;
  localparam int BE = 600;
  localparam int PP = 350;
  logic clk, rst_n, link_sck, cs_n, arr_ready, wel, wip, rd_indeterminate;
  logic [3:0] sdl;
  logic [1:0] io_mode;
  logic [15:0] sector_lock;
  logic [19:0] rd_addr;
  logic [7:0] flag_status;
  fes_arr_op_s arr_op;
  int mismatches, n_tests;

  fes_seq #(.ADDR_W(AW), .SUBSECTOR_ERASE_CYCLES(SSE), .SECTOR_ERASE_CYCLES(SE), .BULK_ERASE_CYCLES(BE),
    .PAGE_PROGRAM_CYCLES(PP)) u_fes_seq (.clk(clk), .rst_n(rst_n), .link_sck(link_sck), .cs_n(cs_n),
    .serial_data_lines(sdl), .io_mode(io_mode), .sector_lock(sector_lock), .arr_ready(arr_ready),
    .rd_addr(rd_addr), .wel(wel), .wip(wip), .flag_status(flag_status), .arr_op(arr_op),
    .rd_indeterminate(rd_indeterminate));
  fes_host u_fes_host (.link_sck(link_sck), .cs_n(cs_n), .serial_data_lines(sdl), .io_mode(io_mode));

  // Clock at 10 MHz.
  always #50 clk = ~clk;

  task chk(input logic [63:0] g, input logic [63:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h, expected %h", $time, g, e);
    end
  endtask : chk

  // Ending a little after the edge keeps every drive and sample clear of the edge itself.
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task s(input logic [7:0] op);
    u_fes_host.frame(op, 32'h0, 0, 0);
    cyc(1);
  endtask : s

  task a(input logic [7:0] op, input logic [19:0] ad, input int ex);
    u_fes_host.frame(op, {12'h0, ad}, AW, ex);
    cyc(1);
  endtask : a

  // Waits, bounded, for busy low (sel 0) or ready high (sel 1).
  task wait_for(input int sel, input int lim);
    int k;
    k = 0;
    while ((sel ? flag_status[7] : !wip) !== 1'b1 && k < lim) begin
      cyc(1);
      k++;
    end
    chk(k < lim, 1'b1);
  endtask : wait_for

  task t_reset;
    chk({wip, wel, flag_status, arr_op}, {2'b00, FSR_RESET, 43'h0});
  endtask : t_reset

  task t_guard;
    a(OP_SE, 20'h10000, 0);
    chk({wip, wel, flag_status}, {2'b00, FSR_RESET});
    s(OP_WREN);
    a(OP_SE, 20'h10000, 1);
    chk({wip, wel, flag_status}, {2'b01, FSR_RESET});
  endtask : t_guard

  task t_protect;
    sector_lock = 16'h0010;
    a(OP_SSE_A, 20'h42345, 0);
    chk({wip, wel, flag_status}, {2'b01, 8'hA2});
    s(OP_CLRFLAG);
    chk(flag_status, FSR_RESET);
    s(OP_BE_A);
    chk({wip, wel, flag_status}, {2'b01, 8'hA2});
    s(OP_CLRFLAG);
    sector_lock = 16'h0;
  endtask : t_protect

  task t_erase(input logic [7:0] op, input logic [1:0] m, input logic [19:0] ad, input fes_kind_e k,
               input logic [31:0] base, input int t);
    io_mode = m;
    s(OP_WREN);
    if (k == FES_K_BULK)
      s(op);
    else
      a(op, ad, 0);
    chk({wip, flag_status}, {1'b1, 8'h00});
    cyc(t - 20);
    chk(wip, 1'b1);
    wait_for(0, 40);
    chk(arr_op, {1'b1, k, base, ERASED_BYTE});
    chk({wel, flag_status}, {1'b0, FSR_RESET});
    io_mode = MODE_SINGLE;
  endtask : t_erase

  task t_timeout;
    arr_ready = 1'b0;
    s(OP_WREN);
    a(OP_SSE_B, 20'h01000, 0);
    wait_for(0, 4 * SSE + 40);
    chk({wel, flag_status}, {1'b0, 8'hA0});
    arr_ready = 1'b1;
    s(OP_CLRFLAG);
    chk(flag_status, FSR_RESET);
  endtask : t_timeout

  task t_nest;
    s(OP_WREN);
    a(OP_SE, 20'h31234, 0);
    cyc(100);
    s(OP_SUSP);
    chk({wip, flag_status}, {1'b1, 8'h40});
    cyc(280);
    chk(flag_status[7], 1'b0);
    wait_for(1, 40);
    chk({wip, flag_status}, {1'b0, 8'hC0});
    rd_addr = 20'h3F000;
    cyc(2);
    chk(rd_indeterminate, 1'b1);
    rd_addr = 20'h40000;
    cyc(2);
    chk(rd_indeterminate, 1'b0);
    a(OP_PP, 20'h30100, 8);
    chk({wip, wel, flag_status}, {2'b01, 8'hD0});
    s(OP_CLRFLAG);
    a(OP_PP, 20'h20100, 8);
    chk({wip, flag_status}, {1'b1, 8'h40});
    s(OP_SUSP);
    chk(flag_status, 8'h44);
    wait_for(1, 320);
    chk({wip, flag_status}, {1'b0, 8'hC4});
    s(OP_RESUME);
    chk({wip, flag_status}, {1'b1, 8'h40});
    wait_for(0, 80);
    chk({arr_op.valid, arr_op.kind, flag_status}, {1'b1, FES_K_PROG, 8'hC0});
    sector_lock = 16'h0008;
    s(OP_RESUME);
    chk({wip, flag_status}, {1'b1, 8'h00});
    wait_for(0, 120);
    chk(arr_op, {1'b1, FES_K_SECT, 32'h30000, ERASED_BYTE});
    sector_lock = 16'h0;
    chk({wel, flag_status}, {1'b0, FSR_RESET});
  endtask : t_nest

  task t_finish;
    s(OP_WREN);
    a(OP_SSE_A, 20'h02000, 0);
    cyc(SSE - 150);
    s(OP_SUSP);
    chk(flag_status[FSR_ESUSP], 1'b1);
    wait_for(0, 200);
    chk({wip, wel, flag_status}, {2'b00, FSR_RESET});
    s(OP_RESUME);
    chk({wip, flag_status}, {1'b0, FSR_RESET});
  endtask : t_finish

  task tally_and_finish;
    $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  // The whole run needs about 5300 cycles; the watchdog allows nearly four times that.
  initial begin
    #2000000;
    mismatches++;
    $display("unexpected at %0t: watchdog expired", $time);
    tally_and_finish;
  end

  // Main sequence.
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    io_mode = MODE_SINGLE;
    sector_lock = 16'h0;
    arr_ready = 1'b1;
    rd_addr = 20'h0;
    mismatches = 0;
    n_tests = 0;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    cyc(2);
    t_reset;
    t_guard;
    t_protect;
    t_erase(OP_SE, MODE_SINGLE, 20'h5ABCD, FES_K_SECT, 32'h50000, SE);
    t_erase(OP_SSE_A, MODE_DUAL, 20'h7B123, FES_K_SUBSECT, 32'h7B000, SSE);
    t_erase(OP_SSE_B, MODE_QUAD, 20'h3C456, FES_K_SUBSECT, 32'h3C000, SSE);
    t_erase(OP_BE_B, MODE_QUAD, 20'h0, FES_K_BULK, 32'h0, BE);
    t_timeout;
    t_nest;
    t_finish;
    tally_and_finish;
  end
endmodule : flash_erase_suspend_sequencer_bench
